// >>> hdl/status_led_pkg.sv
// Shared constants and types for the status LED indicator
package status_led_pkg;

	// Clock and timing
	localparam longint unsigned CLK_FREQ_KHZ       = 200000;
	localparam longint unsigned STARTUP_TIME_MS    = 4000;
	localparam longint unsigned IDENT_TIME_MS      = 30000;
	localparam longint unsigned BLINK_HALF_MS      = 250;
	localparam longint unsigned STARTUP_CYCLES_DFL = STARTUP_TIME_MS * CLK_FREQ_KHZ;
	localparam longint unsigned IDENT_CYCLES_DFL   = IDENT_TIME_MS * CLK_FREQ_KHZ;
	localparam longint unsigned BLINK_HALF_CYC_DFL = BLINK_HALF_MS * CLK_FREQ_KHZ;
	localparam int              TMR_W              = 33;

	// APB map
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  CTRL_OFFS    = 8'h00;
	localparam logic [7:0]  CMD_OFFS     = 8'h04;
	localparam logic [7:0]  STATUS_OFFS  = 8'h08;

	// Control register fields and reset value
	localparam int          CTRL_LINK_EN_BIT = 0;
	localparam int          CTRL_MODE_LSB    = 1;
	localparam logic [31:0] CTRL_RST         = 32'h0000_0000;

	// Command register fields
	localparam int          CMD_ACK_BIT   = 0;
	localparam int          CMD_PING_BIT  = 1;

	// Status register fields
	localparam int          STAT_ON_BIT    = 0;
	localparam int          STAT_STATE_LSB = 1;
	localparam int          STAT_START_BIT = 3;
	localparam int          STAT_IDENT_BIT = 4;
	localparam int          STAT_BLINK_BIT = 5;
	localparam int          STAT_LED_LSB   = 8;

	// Start-up behaviour of the safety output pair
	typedef enum logic [1:0] {
		MODE_AUTO     = 2'b00,
		MODE_START_IL = 2'b01,
		MODE_RESTART  = 2'b10,
		MODE_SPARE    = 2'b11
	} start_mode_t;

	// Safety output pair state
	typedef enum logic [1:0] {
		ST_START  = 2'b00,
		ST_LOCKED = 2'b01,
		ST_FIELD  = 2'b10,
		ST_ON     = 2'b11
	} out_state_t;

	// Saturating down count shared by the start-up and identify timers
	function automatic logic [TMR_W-1:0] cnt_dec(input logic [TMR_W-1:0] cnt);
		cnt_dec = (cnt == '0) ? cnt : cnt - {{(TMR_W-1){1'b0}}, 1'b1};
	endfunction : cnt_dec

endpackage : status_led_pkg

// >>> hdl/blink_if.sv
// Carrier for the shared blink phase
`timescale 1ns/100ps
interface blink_if;
	logic phase;
	logic tick;
	modport gen  (output phase, output tick);
	modport user (input  phase, input  tick);
endinterface : blink_if

// >>> hdl/blink_gen.sv
// Shared blink generator, 50 percent duty
`timescale 1ns/100ps
module blink_gen
	import status_led_pkg::*;
#(
	parameter logic [TMR_W-1:0] HALF_CYCLES = BLINK_HALF_CYC_DFL[TMR_W-1:0]
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Phase out
	blink_if.gen      bl
);

	logic [TMR_W-1:0] div_reg;
	logic             phase_reg;

	// Divider makes a one-cycle enable at each half period
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_reg <= '0;
		end else if (div_reg >= HALF_CYCLES - {{(TMR_W-1){1'b0}}, 1'b1}) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + {{(TMR_W-1){1'b0}}, 1'b1};
		end
	end

	// One phase for every LED so they toggle together
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			phase_reg <= 1'b0;
		end else if (bl.tick) begin
			phase_reg <= ~phase_reg;
		end
	end

	assign bl.tick  = (div_reg >= HALF_CYCLES - {{(TMR_W-1){1'b0}}, 1'b1});
	assign bl.phase = phase_reg;

endmodule : blink_gen

// >>> hdl/status_led_indicator.sv
// Status LED indicator and safety output pair control with APB registers
//
// Function
// - Blue warning LED dark while neither warning field is occupied.
// - Blue warning LED steady when exactly one warning field is occupied.
// - Blue warning LED flashes when both warning fields are occupied.
// - Link LED dark when disabled, blue idle, blue flashing when peer connected.
// - Contamination LED dark, yellow flashing on warning, yellow steady on error.
// - Interlock LED steady while interlock holds outputs but accepts unlock.
// - Interlock LED dark when off or released; flashes with protective field occupied.
// - After power-up all five LEDs lit 4 s: red, yellow, blue, green, green.
// - Identify ping flashes LEDs four and five green for 30 s.
// - Object in protective field switches the safety output pair off.
// - Re-enable only after field clears, automatic or acknowledged per start mode.
`timescale 1ns/100ps
module status_led_indicator
	import status_led_pkg::*;
#(
	parameter logic [TMR_W-1:0] STARTUP_CYCLES = STARTUP_CYCLES_DFL[TMR_W-1:0],
	parameter logic [TMR_W-1:0] IDENT_CYCLES   = IDENT_CYCLES_DFL[TMR_W-1:0],
	parameter logic [TMR_W-1:0] BLINK_HALF_CYC = BLINK_HALF_CYC_DFL[TMR_W-1:0]
) (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// APB slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Internal status conditions
	input  wire logic              prot_field_occ,
	input  wire logic              warn_field1_occ,
	input  wire logic              warn_field2_occ,
	input  wire logic              link_peer_conn,
	input  wire logic              contam_warn,
	input  wire logic              contam_err,
	input  wire logic              fault_err,
	input  wire logic              ack_req,
	// Safety outputs
	output logic      [1:0]        safety_output_pair,
	// Front-panel LEDs
	output logic                   led1_red,
	output logic                   led1_green,
	output logic                   led2_yellow,
	output logic                   led3_blue,
	output logic                   led4_blue,
	output logic                   led4_green,
	output logic                   led5_yellow,
	output logic                   led5_green
);

	blink_if bl ();

	logic [31:0]      ctrl_reg;
	logic [31:0]      rdata_reg;
	logic             ack_cmd_reg;
	logic             ping_cmd_reg;
	logic [TMR_W-1:0] start_cnt_reg;
	logic [TMR_W-1:0] ident_cnt_reg;
	out_state_t       st_reg;
	out_state_t       st_next;
	logic [1:0]       pair_reg;
	logic [7:0]       led_reg;
	logic [7:0]       led_next;

	logic             setup_ph;
	logic             access_ph;
	logic             addr_ok;
	logic             wr_en;
	logic             link_en;
	start_mode_t      mode;
	logic             ilk_en;
	logic             force_off;
	logic             startup_act;
	logic             ident_act;
	logic             ack_any;
	logic             blink;

	// Shared blink source for every flashing pattern
	blink_gen #(
		.HALF_CYCLES (BLINK_HALF_CYC)
	) u_blink (
		.clk_sys (clk_sys),
		.rst     (rst),
		.bl      (bl.gen)
	);

	assign blink = bl.phase;

	// APB decode
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable;
	assign addr_ok   = (paddr == CTRL_OFFS) | (paddr == CMD_OFFS) | (paddr == STATUS_OFFS);
	assign wr_en     = access_ph & pwrite;
	assign pready    = access_ph;
	assign pslverr   = access_ph & ~addr_ok; // Unmapped address answers with an error
	assign prdata    = rdata_reg;

	// Configuration fields
	assign link_en = ctrl_reg[CTRL_LINK_EN_BIT];
	assign mode    = start_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
	assign ilk_en  = (mode != MODE_AUTO);

	// Control register write
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_reg <= CTRL_RST;
		end else if (wr_en && paddr == CTRL_OFFS) begin
			ctrl_reg <= {29'h0000_0000, pwdata[2:0]};
		end
	end

	// Command bits act as one-cycle pulses, nothing is stored
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_cmd_reg  <= 1'b0;
			ping_cmd_reg <= 1'b0;
		end else begin
			ack_cmd_reg  <= wr_en && paddr == CMD_OFFS && pwdata[CMD_ACK_BIT];
			ping_cmd_reg <= wr_en && paddr == CMD_OFFS && pwdata[CMD_PING_BIT];
		end
	end

	// Read data captured in the setup cycle so it comes from a flop
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (setup_ph) begin
			case (paddr)
				CTRL_OFFS: begin
					rdata_reg <= ctrl_reg;
				end
				STATUS_OFFS: begin
					rdata_reg <= {16'h0000, led_reg, 2'b00, blink, ident_act,
						startup_act, st_reg, pair_reg[0]};
				end
				default: begin
					rdata_reg <= 32'h0000_0000; // Command register reads as zero
				end
			endcase
		end
	end

	// Start-up pattern timer, runs once after reset
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			start_cnt_reg <= STARTUP_CYCLES;
		end else begin
			start_cnt_reg <= cnt_dec(start_cnt_reg);
		end
	end

	// Identify timer; a new ping restarts the full time
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ident_cnt_reg <= '0;
		end else if (ping_cmd_reg) begin
			ident_cnt_reg <= IDENT_CYCLES;
		end else begin
			ident_cnt_reg <= cnt_dec(ident_cnt_reg);
		end
	end

	assign startup_act = (st_reg == ST_START);
	assign ident_act   = (ident_cnt_reg != '0);
	assign ack_any     = ack_req | ack_cmd_reg;
	// Contamination error and faults also keep outputs off
	assign force_off   = prot_field_occ | contam_err | fault_err;

	// Safety output pair sequencing
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_START: begin
				if (start_cnt_reg == '0) begin
					if (ilk_en) begin
						st_next = ST_LOCKED;
					end else if (force_off) begin
						st_next = ST_FIELD;
					end else begin
						st_next = ST_ON;
					end
				end
			end
			ST_ON: begin
				if (force_off) begin
					st_next = ST_FIELD;
				end
			end
			ST_FIELD: begin
				if (!force_off) begin
					// Only a full restart interlock waits for the operator
					st_next = (mode == MODE_RESTART) ? ST_LOCKED : ST_ON;
				end
			end
			ST_LOCKED: begin
				if (ack_any && !force_off) begin
					st_next = ST_ON;
				end
			end
			default: begin
				st_next = ST_START;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_reg <= ST_START;
		end else begin
			st_reg <= st_next;
		end
	end

	// Both channels switch together from the same state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pair_reg <= 2'b00;
		end else begin
			pair_reg <= {2{st_next == ST_ON}};
		end
	end

	assign safety_output_pair = pair_reg;

	// LED pattern selection; order: led1 r/g, led2, led3, led4 b/g, led5 y/g
	always_comb begin
		led_next = 8'h00;
		if (startup_act) begin
			led_next = 8'b1_0_1_1_0_1_0_1;
		end else begin
			// First LED
			if (fault_err) begin
				led_next[7] = blink;
			end else if (st_reg == ST_ON) begin
				led_next[6] = 1'b1;
			end else begin
				led_next[7] = 1'b1;
			end
			// Interlock LED; occupied field outranks the ready state
			if (prot_field_occ) begin
				led_next[5] = blink;
			end else if (ilk_en && st_reg == ST_LOCKED) begin
				led_next[5] = 1'b1;
			end else begin
				led_next[5] = 1'b0;
			end
			// Warning LED
			if (warn_field1_occ && warn_field2_occ) begin
				led_next[4] = blink;
			end else if (warn_field1_occ ^ warn_field2_occ) begin
				led_next[4] = 1'b1;
			end else begin
				led_next[4] = 1'b0;
			end
			// Link LED; identify overrides it
			if (ident_act) begin
				led_next[2] = blink;
			end else if (!link_en) begin
				led_next[3] = 1'b0;
			end else if (link_peer_conn) begin
				led_next[3] = blink;
			end else begin
				led_next[3] = 1'b1;
			end
			// Contamination LED; identify overrides it
			if (ident_act) begin
				led_next[0] = blink;
			end else if (contam_err) begin
				led_next[1] = 1'b1;
			end else if (contam_warn) begin
				led_next[1] = blink;
			end else begin
				led_next[1] = 1'b0;
			end
		end
	end

	// LED drive flops, one cycle behind the pattern decision
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			led_reg <= 8'h00;
		end else begin
			led_reg <= led_next;
		end
	end

	assign led1_red    = led_reg[7];
	assign led1_green  = led_reg[6];
	assign led2_yellow = led_reg[5];
	assign led3_blue   = led_reg[4];
	assign led4_blue   = led_reg[3];
	assign led4_green  = led_reg[2];
	assign led5_yellow = led_reg[1];
	assign led5_green  = led_reg[0];

endmodule : status_led_indicator

// >>> tb/status_led_checker.sv
// Port-level assertions for the status LED indicator
`timescale 1ns/100ps
module status_led_checker
	import status_led_pkg::*;
(
	// Clock and reset
	input wire logic              clk_sys,
	input wire logic              rst,
	// APB
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Conditions
	input wire logic              prot_field_occ,
	input wire logic              warn_field1_occ,
	input wire logic              warn_field2_occ,
	input wire logic              fault_err,
	// Outputs
	input wire logic [1:0]        safety_output_pair,
	input wire logic              led1_red,
	input wire logic              led1_green,
	input wire logic              led3_blue
);
	// One domain, so clock and reset are given once
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Bus answers: zero wait, error only off the map
	a_zero_wait:
		assert property (psel && penable |-> pready) else $error("access without ready");
	a_unmapped_err:
		assert property (psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
		else $error("error flag wrong for address");
	a_err_read_zero:
		assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");

	// Safety output pair against the protective field
	a_field_off:
		assert property (prot_field_occ |=> safety_output_pair == 2'h0) else $error("pair stayed on");
	a_reenable_clear:
		assert property ($rose(safety_output_pair[0]) |-> !$past(prot_field_occ))
		else $error("pair on while field occupied");

	// LED patterns once outputs are on, so start-up is over
	a_warn_dark:
		assert property (safety_output_pair == 2'h3 && !warn_field1_occ && !warn_field2_occ
			|=> !led3_blue) else $error("warning led lit");
	a_warn_steady:
		assert property (safety_output_pair == 2'h3 && (warn_field1_occ != warn_field2_occ)
			|=> led3_blue) else $error("warning led dark");
	a_led1_green:
		assert property (safety_output_pair == 2'h3 && !fault_err |=> led1_green && !led1_red)
		else $error("first led not green");
	// Two flashing LEDs must share the phase
	a_blink_phase:
		assert property (warn_field1_occ && warn_field2_occ && fault_err
			|=> led3_blue == led1_red) else $error("flash phases differ");
endmodule : status_led_checker

bind status_led_indicator status_led_checker u_chk (
	.clk_sys            (clk_sys),
	.rst                (rst),
	.paddr              (paddr),
	.psel               (psel),
	.penable            (penable),
	.pwrite             (pwrite),
	.prdata             (prdata),
	.pready             (pready),
	.pslverr            (pslverr),
	.prot_field_occ     (prot_field_occ),
	.warn_field1_occ    (warn_field1_occ),
	.warn_field2_occ    (warn_field2_occ),
	.fault_err          (fault_err),
	.safety_output_pair (safety_output_pair),
	.led1_red           (led1_red),
	.led1_green         (led1_green),
	.led3_blue          (led3_blue)
);

// >>> tb/led_panel.sv
// Front-panel LED model: records which LEDs were seen lit and seen dark
`timescale 1ns/100ps
module led_panel (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// LED drive and window restart
	input  wire logic [7:0] leds,
	input  wire logic       clr,
	// History since restart
	output logic      [7:0] seen_on,
	output logic      [7:0] seen_off
);
	// Both sets hold a bit when that LED flashed in the window
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			seen_on  <= 8'h00;
			seen_off <= 8'h00;
		end else if (clr) begin
			seen_on  <= 8'h00;
			seen_off <= 8'h00;
		end else begin
			seen_on  <= seen_on | leds;
			seen_off <= seen_off | ~leds;
		end
	end
endmodule : led_panel

// >>> tb/status_led_indicator_tb.sv
// Self-checking testbench for the status LED indicator
`timescale 1ns/100ps
module status_led_indicator_tb import status_led_pkg::*;;
	logic              clk_sys, rst, psel, penable, pwrite, pready, pslverr, clr, er;
	logic              prot_field_occ, warn_field1_occ, warn_field2_occ, link_peer_conn;
	logic              contam_warn, contam_err, fault_err, ack_req;
	logic              led1_red, led1_green, led2_yellow, led3_blue;
	logic              led4_blue, led4_green, led5_yellow, led5_green;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [1:0]        safety_output_pair;
	logic [7:0]        leds, son, soff;
	int                err_count, samples_checked;

	// Short counts keep the run brief
	status_led_indicator #(.STARTUP_CYCLES(33'd20), .IDENT_CYCLES(33'd30),
		.BLINK_HALF_CYC(33'd4)) dut (
		.clk_sys            (clk_sys),
		.rst                (rst),
		.paddr              (paddr),
		.psel               (psel),
		.penable            (penable),
		.pwrite             (pwrite),
		.pwdata             (pwdata),
		.prdata             (prdata),
		.pready             (pready),
		.pslverr            (pslverr),
		.prot_field_occ     (prot_field_occ),
		.warn_field1_occ    (warn_field1_occ),
		.warn_field2_occ    (warn_field2_occ),
		.link_peer_conn     (link_peer_conn),
		.contam_warn        (contam_warn),
		.contam_err         (contam_err),
		.fault_err          (fault_err),
		.ack_req            (ack_req),
		.safety_output_pair (safety_output_pair),
		.led1_red           (led1_red),
		.led1_green         (led1_green),
		.led2_yellow        (led2_yellow),
		.led3_blue          (led3_blue),
		.led4_blue          (led4_blue),
		.led4_green         (led4_green),
		.led5_yellow        (led5_yellow),
		.led5_green         (led5_green)
	);
	led_panel u_panel (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.leds     (leds),
		.clr      (clr),
		.seen_on  (son),
		.seen_off (soff)
	);
	assign leds = {led1_red, led1_green, led2_yellow, led3_blue,
		led4_blue, led4_green, led5_yellow, led5_green};

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer, held until ready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Apply conditions, then watch a full blink period
	task obs(input logic [6:0] c, input logic [1:0] p, input logic [7:0] st, input logic [7:0] fl);
		{prot_field_occ, warn_field1_occ, warn_field2_occ, link_peer_conn,
			contam_warn, contam_err, fault_err} <= c;
		repeat (3) @(posedge clk_sys);
		clr <= 1'b1;
		@(posedge clk_sys);
		clr <= 1'b0;
		repeat (12) @(posedge clk_sys);
		chk({30'h0, safety_output_pair}, {30'h0, p});
		chk({24'h0, son}, {24'h0, st | fl});
		chk({24'h0, soff}, {24'h0, ~st});
	endtask : obs

	task wrap_up();
		if (err_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Whole run is well under a thousand cycles
	initial begin
		#50000;
		err_count++;
		wrap_up();
	end

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, clr, ack_req} = 5'h00;
		{prot_field_occ, warn_field1_occ, warn_field2_occ, link_peer_conn} = 4'h0;
		{contam_warn, contam_err, fault_err} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk({24'h0, leds}, 32'hB5);
		apb(1'b0, CTRL_OFFS, 32'h0);
		chk(rd, CTRL_RST);
		apb(1'b0, 8'h0C, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		// Pattern holds to the end of the start-up count, then gives way
		repeat (12) @(posedge clk_sys);
		#1;
		chk({24'h0, leds}, 32'hB5);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({24'h0, leds}, 32'h40);
		obs(7'h00, 2'h3, 8'h40, 8'h00);
		// Status word; blink phase bit masked as it runs free
		apb(1'b0, STATUS_OFFS, 32'h0);
		chk(rd & 32'hFFFF_FFDF, 32'h0000_4007);
		apb(1'b1, CTRL_OFFS, 32'h1);
		apb(1'b0, CTRL_OFFS, 32'h0);
		chk(rd, 32'h1);
		obs(7'h00, 2'h3, 8'h48, 8'h00);
		obs(7'h08, 2'h3, 8'h40, 8'h08);
		obs(7'h20, 2'h3, 8'h58, 8'h00);
		obs(7'h30, 2'h3, 8'h48, 8'h10);
		obs(7'h04, 2'h3, 8'h48, 8'h02);
		obs(7'h02, 2'h0, 8'h8A, 8'h00);
		obs(7'h40, 2'h0, 8'h88, 8'h20);
		obs(7'h00, 2'h3, 8'h48, 8'h00);
		obs(7'h31, 2'h0, 8'h08, 8'h90);
		obs(7'h00, 2'h3, 8'h48, 8'h00);
		apb(1'b1, CMD_OFFS, 32'h2);
		obs(7'h00, 2'h3, 8'h40, 8'h05);
		repeat (20) @(posedge clk_sys);
		obs(7'h00, 2'h3, 8'h48, 8'h00);
		// Restart interlock mode with link on
		apb(1'b1, CTRL_OFFS, 32'h5);
		obs(7'h40, 2'h0, 8'h88, 8'h20);
		obs(7'h00, 2'h0, 8'hA8, 8'h00);
		ack_req <= 1'b1;
		@(posedge clk_sys);
		ack_req <= 1'b0;
		obs(7'h00, 2'h3, 8'h48, 8'h00);
		// Second unlock through the command register
		obs(7'h40, 2'h0, 8'h88, 8'h20);
		obs(7'h00, 2'h0, 8'hA8, 8'h00);
		apb(1'b1, CMD_OFFS, 32'h1);
		obs(7'h00, 2'h3, 8'h48, 8'h00);
		// Start interlock mode restarts by itself, interlock LED dark
		apb(1'b1, CTRL_OFFS, 32'h3);
		obs(7'h40, 2'h0, 8'h88, 8'h20);
		obs(7'h00, 2'h3, 8'h48, 8'h00);
		wrap_up();
	end
endmodule : status_led_indicator_tb
